/* hps_pkg.sv */
// hps_pkg: register map, field positions, reset values and timing for the headphone stage block
// assumes a single 25 MHz register clock shared by every user of the package
package hps_pkg;
  // register map
  localparam logic [7:0] ADDR_STAGE_CTRL = 8'h5A;
  localparam logic [7:0] ADDR_CAL_STATUS = 8'h4D;
  localparam logic [7:0] STAGE_CTRL_RESET = 8'h00;
  localparam logic [3:0] CAL_STATUS_RESET = 4'h0;
  // field positions in the stage control register
  localparam int BIT_L_SHORT_REMOVE = 7;
  localparam int BIT_L_OUTPUT = 6;
  localparam int BIT_L_INTERMEDIATE = 5;
  localparam int BIT_L_INPUT = 4;
  localparam int BIT_R_SHORT_REMOVE = 3;
  localparam int BIT_R_OUTPUT = 2;
  localparam int BIT_R_INTERMEDIATE = 1;
  localparam int BIT_R_INPUT = 0;
  // calibration status field position in its register
  localparam int CAL_DONE_LSB = 8;
  localparam int CAL_DONE_MSB = 11;
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1000000));
  localparam int SETTLE_CNT_W = 10;
endpackage

/* hps_settle_timer.sv */
// hps_settle_timer: counts settling time since a channel's input stage was switched on
// assumes i_input_en is a registered level on the same clock
module hps_settle_timer #(
  parameter int CYCLES = hps_pkg::SETTLE_CYCLES,
  parameter int CNT_W = hps_pkg::SETTLE_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_input_en,
  output logic o_settled
);
  // elaboration check: a count the counter cannot reach would never settle
  if (CYCLES < 1 || CYCLES >= (1 << CNT_W))
  begin
    $error("settle count does not fit the counter");
  end

  logic [CNT_W-1:0] count;
  wire at_end = (count == CNT_W'(CYCLES));

  // count runs while the input stage is on, holds once it reaches CYCLES, restarts when it drops
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || !i_input_en)
    begin
      count <= '0;
      o_settled <= 1'b0;
    end
    else
    begin
      if (!at_end)
        count <= count + CNT_W'(1);
      o_settled <= at_end;
    end
  end
endmodule

/* hps_stage_ctrl.sv */
// hps_stage_ctrl: headphone stage enable register, its static enables and calibration status
// assumes a plain same-clock register port; calibration done levels come from another block
// register map
//   0x5A stage control, read-write, eight enable bits, all zero after reset
//   0x4D calibration status, read-only, done levels at bits 11:8
//   any other address reads zero and ignores writes
// control register layout, bit 7 down to bit 0
//   7 left short removal, 6 left output, 5 left intermediate, 4 left input
//   3 right short removal, 2 right output, 1 right intermediate, 0 right input
// usual power-up order per channel, kept by software
//   input stage on
//   wait for the settle flag, at least 20us
//   intermediate stage on, then schedule offset cancellation
//   output stage on once cancellation is scheduled
//   short removal last
// timing
//   one register clock, synchronous active-low reset
//   write taken at a strobe edge, enable pins follow one cycle later
//   read data stand for the one cycle after the read strobe, zero otherwise
//   status bits lag their inputs by two clocks of resynchronisation
// limitations
//   order and spacing are not enforced: a bad write goes straight to the pins
//   the settle flag is advisory and restarts whenever the input stage drops
//   a reset mid-run drops every stage at once, with no ordered power-down
//   the four read-word bits above the status field, 15:12, always read zero here
//
// Local design decision: the address-and-strobe port.

module hps_stage_ctrl (
  // register port
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // calibration done levels from the offset engine
  input wire logic [3:0] i_cal_done,
  // stage enables, static levels
  output logic o_left_hp_short_remove,
  output logic o_left_hp_output_stage_en,
  output logic o_left_hp_intermediate_stage_en,
  output logic o_left_hp_input_stage_en,
  output logic o_right_hp_short_remove,
  output logic o_right_hp_output_stage_en,
  output logic o_right_hp_intermediate_stage_en,
  output logic o_right_hp_input_stage_en,
  // advisory settle flags
  output logic o_left_settled,
  output logic o_right_settled
);

  // control register and status resync flops
  logic [7:0] stage_ctrl;
  logic [3:0] cal_meta;
  logic [3:0] cal_sync;

  // elaboration checks: refuse a field map that the eight flops cannot serve
  localparam logic [7:0] FIELD_MASK = 8'(
    (1 << hps_pkg::BIT_L_SHORT_REMOVE) | (1 << hps_pkg::BIT_L_OUTPUT) |
    (1 << hps_pkg::BIT_L_INTERMEDIATE) | (1 << hps_pkg::BIT_L_INPUT) |
    (1 << hps_pkg::BIT_R_SHORT_REMOVE) | (1 << hps_pkg::BIT_R_OUTPUT) |
    (1 << hps_pkg::BIT_R_INTERMEDIATE) | (1 << hps_pkg::BIT_R_INPUT));
  if (FIELD_MASK != 8'hFF)
  begin
    $error("enable fields overlap or fall outside the register");
  end

  // status field must be exactly four bits and inside the read word
  if (hps_pkg::CAL_DONE_MSB - hps_pkg::CAL_DONE_LSB != 3 || hps_pkg::CAL_DONE_MSB > 15)
  begin
    $error("status field does not fit the read word");
  end

  // both registers need their own address or one would shadow the other
  if (hps_pkg::ADDR_STAGE_CTRL == hps_pkg::ADDR_CAL_STATUS)
  begin
    $error("register addresses collide");
  end

  // reset values must be all zero, the pins start with every stage off
  if (hps_pkg::STAGE_CTRL_RESET != 8'h00 || hps_pkg::CAL_STATUS_RESET != 4'h0)
  begin
    $error("reset values must be zero");
  end

  // settle count is reckoned in whole megahertz; a fraction would shorten it
  if (hps_pkg::CLK_HZ % 1000000 != 0)
  begin
    $error("clock is not a whole number of megahertz");
  end

  // address decode
  wire sel_ctrl = (i_addr == hps_pkg::ADDR_STAGE_CTRL);
  wire sel_cal = (i_addr == hps_pkg::ADDR_CAL_STATUS);
  wire wr_ctrl = i_wr && sel_ctrl;

  // read words; status placed by its package position, everything else zero
  wire [15:0] ctrl_word = {8'h00, stage_ctrl};
  wire [15:0] cal_word = 16'(cal_sync) << hps_pkg::CAL_DONE_LSB;
  wire [15:0] map_word = sel_ctrl ? ctrl_word : (sel_cal ? cal_word : 16'h0000);
  // idle bus reads zero so a stale word is never taken for an answer
  wire [15:0] next_rdata = i_rd ? map_word : 16'h0000;

  // field decode, left channel: one named wire per enable
  wire next_left_short_remove = stage_ctrl[hps_pkg::BIT_L_SHORT_REMOVE];
  wire next_left_output_en = stage_ctrl[hps_pkg::BIT_L_OUTPUT];
  wire next_left_intermediate_en = stage_ctrl[hps_pkg::BIT_L_INTERMEDIATE];
  wire next_left_input_en = stage_ctrl[hps_pkg::BIT_L_INPUT];
  // field decode, right channel
  wire next_right_short_remove = stage_ctrl[hps_pkg::BIT_R_SHORT_REMOVE];
  wire next_right_output_en = stage_ctrl[hps_pkg::BIT_R_OUTPUT];
  wire next_right_intermediate_en = stage_ctrl[hps_pkg::BIT_R_INTERMEDIATE];
  wire next_right_input_en = stage_ctrl[hps_pkg::BIT_R_INPUT];

  // control register; ordering and 20us spacing are software's duty, not enforced
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      stage_ctrl <= hps_pkg::STAGE_CTRL_RESET;
    else if (wr_ctrl)
      stage_ctrl <= i_wdata;
  end

  // calibration levels come from another engine, resynchronised for safety
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      cal_meta <= hps_pkg::CAL_STATUS_RESET;
      cal_sync <= hps_pkg::CAL_STATUS_RESET;
    end
    else
    begin
      cal_meta <= i_cal_done;
      cal_sync <= cal_meta;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_rdata <= 16'h0000;
    else
      o_rdata <= next_rdata;
  end

  // left enables, one flop each, follow the register a cycle later
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_left_hp_short_remove <= 1'b0;
      o_left_hp_output_stage_en <= 1'b0;
      o_left_hp_intermediate_stage_en <= 1'b0;
      o_left_hp_input_stage_en <= 1'b0;
    end
    else
    begin
      o_left_hp_short_remove <= next_left_short_remove;
      o_left_hp_output_stage_en <= next_left_output_en;
      o_left_hp_intermediate_stage_en <= next_left_intermediate_en;
      o_left_hp_input_stage_en <= next_left_input_en;
    end
  end

  // right enables, same one-cycle lag so both channels move together
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_right_hp_short_remove <= 1'b0;
      o_right_hp_output_stage_en <= 1'b0;
      o_right_hp_intermediate_stage_en <= 1'b0;
      o_right_hp_input_stage_en <= 1'b0;
    end
    else
    begin
      o_right_hp_short_remove <= next_right_short_remove;
      o_right_hp_output_stage_en <= next_right_output_en;
      o_right_hp_intermediate_stage_en <= next_right_intermediate_en;
      o_right_hp_input_stage_en <= next_right_input_en;
    end
  end

  // settle timers, one per channel: index 1 left, index 0 right
  wire [1:0] input_en = {o_left_hp_input_stage_en, o_right_hp_input_stage_en};
  wire [1:0] settled;
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_settle
    // advisory only: tells software when the intermediate stage may follow
    hps_settle_timer u_settle (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_input_en(input_en[ch]),
      .o_settled(settled[ch])
    );
  end
  // outputs straight from the timer flops
  assign o_left_settled = settled[1];
  assign o_right_settled = settled[0];
endmodule

/* hps_stage_ctrl_asserts.sv */
// checker for the headphone stage enable register
// assumes a bind onto hps_stage_ctrl, one clock, sync active-low reset
module hps_stage_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0] i_cal_done,
  input wire logic [15:0] o_rdata,
  input wire logic o_left_hp_short_remove,
  input wire logic o_left_hp_output_stage_en,
  input wire logic o_left_hp_intermediate_stage_en,
  input wire logic o_left_hp_input_stage_en,
  input wire logic o_right_hp_short_remove,
  input wire logic o_right_hp_output_stage_en,
  input wire logic o_right_hp_intermediate_stage_en,
  input wire logic o_right_hp_input_stage_en,
  input wire logic o_left_settled,
  input wire logic o_right_settled
);
  // enables gathered in register bit order
  wire logic [7:0] en = {o_left_hp_short_remove, o_left_hp_output_stage_en,
    o_left_hp_intermediate_stage_en, o_left_hp_input_stage_en, o_right_hp_short_remove,
    o_right_hp_output_stage_en, o_right_hp_intermediate_stage_en, o_right_hp_input_stage_en};
  wire logic wr_c = i_wr && i_addr == hps_pkg::ADDR_STAGE_CTRL;
  wire logic rd_c = i_rd && i_addr == hps_pkg::ADDR_STAGE_CTRL;
  wire logic rd_s = i_rd && i_addr == hps_pkg::ADDR_CAL_STATUS;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_WRITE: assert property (wr_c |-> ##2 en == $past(i_wdata, 2))
    else $error("enables differ");
  AST_HOLD: assert property (!wr_c |-> ##2 $stable(en))
    else $error("enable moved");
  AST_RD_CTRL: assert property (rd_c |=> o_rdata == {8'h00, en})
    else $error("bad readback");
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("idle rdata");
  AST_UNMAPPED: assert property (i_rd && !rd_c && !rd_s |=> o_rdata == 16'h0000)
    else $error("unmapped rdata");
  // status lags the input by the two sync flops, so only judged well past reset
  AST_CAL: assert property (rd_s && $past(i_resetn) && $past(i_resetn, 2)
    |=> o_rdata == {4'h0, $past(i_cal_done, 3), 8'h00})
    else $error("bad status");
  AST_L_DROP: assert property (!o_left_hp_input_stage_en |=> !o_left_settled)
    else $error("left settled");
  AST_R_DROP: assert property (!o_right_hp_input_stage_en |=> !o_right_settled)
    else $error("right settled");
  // reset itself is the subject here, so this one is never disabled
  AST_RST: assert property (@(posedge i_clk) disable iff (1'b0) !i_resetn |=>
    en == 8'h00 && o_rdata == 16'h0000 && !o_left_settled && !o_right_settled)
    else $error("reset left state");
  cover property (wr_c);
  cover property (rd_s);
  cover property ($rose(o_left_settled));
  cover property (wr_c && i_wdata == 8'hFF);
endmodule
bind hps_stage_ctrl hps_stage_ctrl_asserts u_hps_stage_ctrl_asserts (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_cal_done(i_cal_done),
  .o_rdata(o_rdata),
  .o_left_hp_short_remove(o_left_hp_short_remove),
  .o_left_hp_output_stage_en(o_left_hp_output_stage_en),
  .o_left_hp_intermediate_stage_en(o_left_hp_intermediate_stage_en),
  .o_left_hp_input_stage_en(o_left_hp_input_stage_en),
  .o_right_hp_short_remove(o_right_hp_short_remove),
  .o_right_hp_output_stage_en(o_right_hp_output_stage_en),
  .o_right_hp_intermediate_stage_en(o_right_hp_intermediate_stage_en),
  .o_right_hp_input_stage_en(o_right_hp_input_stage_en),
  .o_left_settled(o_left_settled),
  .o_right_settled(o_right_settled)
);

/* tb_hps_stage_ctrl.sv */
// testbench: register accesses with expected enables and readback
// assumes package, design and checker compiled first
module tb_hps_stage_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic [3:0] i_cal_done = 4'h0;
  wire logic [7:0] en;
  wire logic [15:0] o_rdata;
  wire logic [1:0] st;
  int miscompares = 0, checks_done = 0;
  hps_stage_ctrl u_hps_stage_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cal_done(i_cal_done),
    .o_left_hp_short_remove(en[7]), .o_left_hp_output_stage_en(en[6]),
    .o_left_hp_intermediate_stage_en(en[5]), .o_left_hp_input_stage_en(en[4]),
    .o_right_hp_short_remove(en[3]), .o_right_hp_output_stage_en(en[2]),
    .o_right_hp_intermediate_stage_en(en[1]), .o_right_hp_input_stage_en(en[0]),
    .o_left_settled(st[1]), .o_right_settled(st[0]));
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one strobe cycle; read data sampled just after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 8'h00);
    chk("rdata", e, o_rdata);
  endtask
  // enables follow one cycle after the register
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    acc(1'b1, a, d);
    @(posedge i_clk);
    #1;
    chk("enables", {8'h00, e}, {8'h00, en});
  endtask
  task automatic rst;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk("reset enables", 16'h0000, {14'h0000, st} | {8'h00, en});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rst;
    rd(hps_pkg::ADDR_STAGE_CTRL, 16'h0000);
    for (int i = 0; i < 8; i++)
      wr(hps_pkg::ADDR_STAGE_CTRL, 8'h01 << i, 8'h01 << i);
    wr(hps_pkg::ADDR_CAL_STATUS, 8'h00, 8'h80);
    wr(8'h33, 8'h00, 8'h80);
    rd(8'h33, 16'h0000);
    $display("bit and map test done");
    @(posedge i_clk) i_cal_done <= 4'h6;
    repeat (3) @(posedge i_clk);
    rd(hps_pkg::ADDR_CAL_STATUS, 16'h0600);
    wr(hps_pkg::ADDR_STAGE_CTRL, 8'h11, 8'h11);
    repeat (hps_pkg::SETTLE_CYCLES - 20) @(posedge i_clk);
    #1;
    chk("early settle", 16'h0000, {14'h0000, st});
    repeat (30) @(posedge i_clk);
    #1;
    chk("settle", 16'h0003, {14'h0000, st});
    wr(hps_pkg::ADDR_STAGE_CTRL, 8'h33, 8'h33);
    @(posedge i_clk) i_cal_done <= 4'h3;
    repeat (3) @(posedge i_clk);
    rd(hps_pkg::ADDR_CAL_STATUS, 16'h0300);
    wr(hps_pkg::ADDR_STAGE_CTRL, 8'h77, 8'h77);
    wr(hps_pkg::ADDR_STAGE_CTRL, 8'hFF, 8'hFF);
    rd(hps_pkg::ADDR_STAGE_CTRL, 16'h00FF);
    wr(hps_pkg::ADDR_STAGE_CTRL, 8'hEE, 8'hEE);
    @(posedge i_clk);
    #1;
    chk("settle drop", 16'h0000, {14'h0000, st});
    rd(hps_pkg::ADDR_STAGE_CTRL, 16'h00EE);
    @(posedge i_clk);
    rst;
    rd(hps_pkg::ADDR_STAGE_CTRL, 16'h0000);
    $display("sequence and reset test done");
    conclude;
  end
  // the run needs under a thousand cycles; the limit allows five thousand
  initial
  begin
    #200000;
    miscompares++;
    conclude;
  end
endmodule
